// File: hdl/sdcmd_decode.sv
// Command decoder for one chip-select half of the module
`timescale 1ns/10ps
`default_nettype none
module sdcmd_decode
  import sdcmd_pkg::*;
(
  input wire logic cs_n_i, // Chip select, active low
  input wire logic ras_n_i, // Row strobe, active low
  input wire logic cas_n_i, // Column strobe, active low
  input wire logic we_n_i, // Write enable, active low
  output sdcmd_cmd_t cmd_o // Decoded command
);

  function automatic sdcmd_cmd_t decode(input logic cs_n,
                                        input logic [2:0] rcw);
    sdcmd_cmd_t c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_DESEL;
    end else begin
      unique case (rcw)
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_RD;
        3'h4: c = CMD_WR;
        3'h6: c = CMD_BST;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_LMR;
      endcase
    end
    return c;
  endfunction : decode

  assign cmd_o = decode(cs_n_i, {ras_n_i, cas_n_i, we_n_i});

endmodule : sdcmd_decode
`default_nettype wire

// File: hdl/sdcmd_device.sv
// Memory module end: input register, decoder, bank and burst control
`timescale 1ns/10ps
`default_nettype none
`include "sdcmd_defines.svh"
module sdcmd_device
  import sdcmd_pkg::*;
#(
  parameter int LANES = 8,
  parameter int MAX_CL = 3
)
(
  input wire logic clk_i, // Module clock
  input wire logic rst_i, // Synchronous reset, active high
  sdcmd_if.dev link, // Pins from the controller
  output logic acc_rd_o, // Read beat request, data due same cycle
  output logic [1:0] acc_bank_o, // Bank of the current beat
  output logic [12:0] acc_row_o, // Open row of that bank
  output logic [10:0] acc_col_o, // Column of the current beat
  input wire logic [8*LANES-1:0] rd_data_i, // Array read data
  output logic wr_valid_o, // Write beat strobe
  output logic [1:0] wr_bank_o, // Write bank
  output logic [12:0] wr_row_o, // Write row
  output logic [10:0] wr_col_o, // Write column
  output logic [8*LANES-1:0] wr_data_o, // Write data
  output logic [LANES-1:0] wr_lane_en_o, // Lanes to store
  output logic refresh_o, // Auto refresh pulse
  output logic [12:0] mode_reg_o, // Base mode register
  output logic [12:0] ext_mode_reg_o, // Extended mode register
  output sdcmd_pwr_t power_state_o, // Power state
  output logic input_buf_en_o, // Input buffers powered
  output logic [3:0] bank_open_o, // Bank has an open row
  output logic spd_clk_rise_o, // Serial clock rising edge pulse
  output logic [2:0] spd_strap_o // Presence-detect address straps
);

  // ************************
  // Parameter checks and helpers
  // ************************
  if (LANES < 2 || LANES % 2 != 0) begin : g_bad_lanes
    $error("LANES must be even and at least 2");
  end
  if (MAX_CL < 3 || MAX_CL > 7) begin : g_bad_cl
    $error("MAX_CL must lie in 3..7");
  end

  function automatic logic [10:0] burst_last(input logic [2:0] bl);
    logic [10:0] n;
    unique case (bl)
      3'h0: n = 11'h000;
      3'h1: n = 11'h001;
      3'h2: n = 11'h003;
      3'h3: n = 11'h007;
      default: n = 11'h7ff;
    endcase
    return n;
  endfunction : burst_last

  function automatic logic [LANES-1:0] half_lanes(input logic [1:0] h);
    return {{(LANES/2){h[1]}}, {(LANES/2){h[0]}}};
  endfunction : half_lanes

  function automatic int unsigned cl_idx(input logic [2:0] cl);
    int unsigned i;
    i = 0;
    if (int'(cl) > MAX_CL) i = MAX_CL - 2;
    else if (cl > 3'h2) i = int'(cl) - 2;
    return i;
  endfunction : cl_idx

  // ************************
  // Pin synchronisers
  // ************************
  logic [1:0] cke_sync_r, regm_sync_r, scl_sync_r;
  logic [2:0] strap_sync_r;
  logic scl_prev_r;
  logic regmode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_sync_r <= 2'h0;
      regm_sync_r <= 2'h0;
      scl_sync_r <= 2'h3;
      scl_prev_r <= 1'b1;
      spd_clk_rise_o <= 1'b0;
      strap_sync_r <= 3'h0;
      spd_strap_o <= 3'h0;
    end else begin
      cke_sync_r <= {cke_sync_r[0], link.clock_gate_in};
      regm_sync_r <= {regm_sync_r[0], link.register_mode_sel};
      scl_sync_r <= {scl_sync_r[0], link.spd_serial_clk};
      scl_prev_r <= scl_sync_r[1];
      spd_clk_rise_o <= scl_sync_r[1] & ~scl_prev_r;
      strap_sync_r <= link.spd_addr_strap;
      spd_strap_o <= strap_sync_r;
    end
  end

  assign regmode = regm_sync_r[1];

  // ************************
  // Input register stages
  // ************************
  sdcmd_pwr_t pwr_r;
  sdcmd_ca_t s1_r, s2_r, ca;
  logic [LANES-1:0] s1_mask_r, s2_mask_r, msk;
  logic [8*LANES-1:0] s1_dq_r;

  assign input_buf_en_o = (pwr_r == PW_RUN) || (pwr_r == PW_SUSP);

  // Every stage runs off the one module clock reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= `SDCMD_CA_IDLE;
      s2_r <= `SDCMD_CA_IDLE;
      s1_mask_r <= '0;
      s2_mask_r <= '0;
      s1_dq_r <= '0;
    end else if (input_buf_en_o) begin
      s1_r <= {link.chip_select_n_high_half, link.chip_select_n_low_half,
               link.row_strobe_n, link.col_strobe_n, link.write_en_n,
               link.clock_gate_in, link.bank_select, link.row_col_address};
      s2_r <= s1_r;
      s1_mask_r <= link.byte_lane_mask;
      s2_mask_r <= s1_mask_r;
      s1_dq_r <= link.dq;
    end
  end

  assign ca = regmode ? s2_r : s1_r;
  assign msk = regmode ? s2_mask_r : s1_mask_r;

  // ************************
  // Command decode
  // ************************
  sdcmd_cmd_t half_cmd [2];
  sdcmd_cmd_t cmd;

  for (genvar h = 0; h < 2; h++) begin : g_half
    sdcmd_decode u_dec (
      .cs_n_i(ca.cs_n[h]),
      .ras_n_i(ca.ras_n),
      .cas_n_i(ca.cas_n),
      .we_n_i(ca.we_n),
      .cmd_o(half_cmd[h])
    );
  end

  assign cmd = (half_cmd[0] != CMD_DESEL) ? half_cmd[0] : half_cmd[1];

  // ************************
  // Power state
  // ************************
  logic [1:0] hold_r;
  logic bst_act_r, run;

  // Stale register contents after wake-up must not re-enter power-down
  assign run = (pwr_r == PW_RUN) && ca.cke && (hold_r == 2'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_r <= PW_RUN;
      hold_r <= 2'h0;
    end else begin
      unique case (pwr_r)
        PW_RUN: begin
          if (hold_r != 2'h0) begin
            hold_r <= hold_r - 2'h1;
          end else if (!ca.cke) begin
            if (bst_act_r) pwr_r <= PW_SUSP;
            else if (cmd == CMD_REF) pwr_r <= PW_SREF;
            else pwr_r <= PW_PDN;
          end
        end
        PW_SUSP: begin
          if (ca.cke) pwr_r <= PW_RUN;
        end
        PW_PDN, PW_SREF: begin
          if (cke_sync_r[1]) begin
            pwr_r <= PW_RUN;
            hold_r <= regmode ? 2'h2 : 2'h1;
          end
        end
      endcase
    end
  end

  assign power_state_o = pwr_r;

  // ************************
  // Burst control
  // ************************
  logic [10:0] bst_col_r, bst_left_r, cur_col, cur_left, wrap;
  logic [1:0] bst_bank_r, bst_half_r, cur_bank, cur_half;
  logic bst_wr_r, bst_ap_r, cur_wr, cur_ap, start, beat, last, full;
  logic [12:0] row_r [4];

  assign start = run && (cmd == CMD_RD || cmd == CMD_WR);
  assign beat = start || (run && bst_act_r && cmd != CMD_BST);
  assign wrap = burst_last(mode_reg_o[`SDCMD_MR_BL_LSB +: 3]);
  assign full = mode_reg_o[`SDCMD_MR_BL_LSB +: 3] == `SDCMD_BL_FULL;
  assign cur_col = start ? {ca.a[11], ca.a[9:0]} : bst_col_r;
  assign cur_left = start ? wrap : bst_left_r;
  assign cur_bank = start ? ca.ba : bst_bank_r;
  assign cur_half = start ? ~ca.cs_n : bst_half_r;
  assign cur_wr = start ? (cmd == CMD_WR) : bst_wr_r;
  assign cur_ap = start ? ca.a[`SDCMD_AP_BIT] : bst_ap_r;
  assign last = (cur_left == 11'h000) && !full;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bst_act_r <= 1'b0;
      bst_col_r <= 11'h000;
      bst_left_r <= 11'h000;
      bst_bank_r <= 2'h0;
      bst_half_r <= 2'h0;
      bst_wr_r <= 1'b0;
      bst_ap_r <= 1'b0;
    end else if (run) begin
      bst_act_r <= beat && !last;
      bst_col_r <= (cur_col & ~wrap) | ((cur_col + 11'h001) & wrap);
      bst_left_r <= cur_left - 11'h001;
      bst_bank_r <= cur_bank;
      bst_half_r <= cur_half;
      bst_wr_r <= cur_wr;
      bst_ap_r <= cur_ap;
    end
  end

  assign acc_rd_o = beat && !cur_wr;
  assign acc_bank_o = cur_bank;
  assign acc_row_o = row_r[cur_bank];
  assign acc_col_o = cur_col;

  // ************************
  // Banks and mode registers
  // ************************
  logic [3:0] open_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_r <= 4'h0;
      for (int b = 0; b < 4; b++) row_r[b] <= 13'h0000;
    end else if (run) begin
      if (beat && last && cur_ap) open_r[cur_bank] <= 1'b0;
      if (cmd == CMD_ACT) begin
        open_r[ca.ba] <= 1'b1;
        row_r[ca.ba] <= ca.a;
      end else if (cmd == CMD_PRE) begin
        if (ca.a[`SDCMD_AP_BIT]) open_r <= 4'h0;
        else open_r[ca.ba] <= 1'b0;
      end
    end
  end

  assign bank_open_o = open_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg_o <= `SDCMD_MR_RESET;
      ext_mode_reg_o <= `SDCMD_EMR_RESET;
      refresh_o <= 1'b0;
    end else begin
      refresh_o <= run && (cmd == CMD_REF);
      if (run && cmd == CMD_LMR) begin
        if (ca.ba == 2'h0) mode_reg_o <= ca.a;
        else if (ca.ba == 2'h1) ext_mode_reg_o <= ca.a;
      end
    end
  end

  // ************************
  // Write and read data paths
  // ************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_valid_o <= 1'b0;
      wr_bank_o <= 2'h0;
      wr_row_o <= 13'h0000;
      wr_col_o <= 11'h000;
      wr_data_o <= '0;
      wr_lane_en_o <= '0;
    end else begin
      wr_valid_o <= beat && cur_wr;
      if (beat && cur_wr) begin
        wr_bank_o <= cur_bank;
        wr_row_o <= row_r[cur_bank];
        wr_col_o <= cur_col;
        wr_data_o <= s1_dq_r;
        wr_lane_en_o <= ~msk & half_lanes(cur_half);
      end
    end
  end

  // Index 0 is the live beat; CAS latency picks the tap
  logic [8*LANES-1:0] rdat_d [MAX_CL-1];
  logic [LANES-1:0] rlane_d [MAX_CL-1];
  logic [8*LANES-1:0] rdat_r [MAX_CL-2];
  logic [LANES-1:0] rlane_r [MAX_CL-2];
  logic [8*LANES-1:0] dq_r;
  logic [LANES-1:0] dq_oe_n_r;
  int unsigned tap;

  assign rdat_d[0] = rd_data_i;
  assign rlane_d[0] = {LANES{acc_rd_o}} & half_lanes(cur_half);
  for (genvar i = 1; i < MAX_CL - 1; i++) begin : g_tap
    assign rdat_d[i] = rdat_r[i-1];
    assign rlane_d[i] = rlane_r[i-1];
  end
  assign tap = cl_idx(mode_reg_o[`SDCMD_MR_CL_LSB +: 3]);

  // The pipe does not stall in clock suspend, a known limitation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < MAX_CL - 2; i++) begin
        rdat_r[i] <= '0;
        rlane_r[i] <= '0;
      end
      dq_r <= '0;
      dq_oe_n_r <= '1;
    end else begin
      for (int i = 0; i < MAX_CL - 2; i++) begin
        rdat_r[i] <= rdat_d[i];
        rlane_r[i] <= rlane_d[i];
      end
      dq_r <= rdat_d[tap];
      dq_oe_n_r <= ~rlane_d[tap] | msk;
    end
  end

  assign link.dev_dq = dq_r;
  assign link.dev_dq_oe_n = dq_oe_n_r;

endmodule : sdcmd_device
`default_nettype wire

// File: hdl/sdcmd_host.sv
// Controller end: drives commands, masks, data and the serial clock
`timescale 1ns/10ps
`default_nettype none
`include "sdcmd_defines.svh"
module sdcmd_host
  import sdcmd_pkg::*;
#(
  parameter int LANES = 8,
  parameter int SPD_HALF = `SDCMD_SPD_HALF
)
(
  input wire logic clk_i, // Controller clock
  input wire logic rst_i, // Synchronous reset, active high
  sdcmd_if.host link, // Pins to the module
  input wire logic cmd_valid_i, // Issue a command this cycle
  input wire sdcmd_cmd_t cmd_i, // Command to issue
  input wire logic [1:0] cs_half_i, // Halves to select
  input wire logic [1:0] bank_i, // Bank
  input wire logic [12:0] addr_i, // Row, column or opcode
  input wire logic cke_i, // Clock gate level
  input wire logic [LANES-1:0] mask_i, // Byte lane masks
  input wire logic regmode_i, // Registered mode
  input wire logic [2:0] cl_i, // Programmed CAS latency
  input wire logic wr_drive_i, // Drive write data this beat
  input wire logic [8*LANES-1:0] wr_data_i, // Write data
  input wire logic [2:0] strap_i, // Presence-detect straps
  input wire logic spd_run_i, // Run the serial clock
  output logic rd_valid_o, // Read data beat valid
  output logic [8*LANES-1:0] rd_data_o // Read data
);

  if (SPD_HALF < 1) begin : g_bad_half
    $error("SPD_HALF must be at least 1");
  end

  function automatic logic [2:0] strobes(input sdcmd_cmd_t c);
    logic [2:0] s;
    s = 3'h7;
    unique case (c)
      CMD_ACT: s = 3'h3;
      CMD_RD: s = 3'h5;
      CMD_WR: s = 3'h4;
      CMD_BST: s = 3'h6;
      CMD_PRE: s = 3'h2;
      CMD_REF: s = 3'h1;
      CMD_LMR: s = 3'h0;
      default: s = 3'h7;
    endcase
    return s;
  endfunction : strobes

  // ************************
  // Command pins
  // ************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {link.chip_select_n_high_half, link.chip_select_n_low_half} <= 2'h3;
      {link.row_strobe_n, link.col_strobe_n, link.write_en_n} <= 3'h7;
      link.clock_gate_in <= 1'b0;
      link.byte_lane_mask <= '0;
      link.bank_select <= 2'h0;
      link.row_col_address <= 13'h0000;
      link.register_mode_sel <= 1'b0;
      link.spd_addr_strap <= 3'h0;
    end else begin
      {link.chip_select_n_high_half, link.chip_select_n_low_half} <=
        (cmd_valid_i && cmd_i != CMD_DESEL) ? ~cs_half_i : 2'h3;
      {link.row_strobe_n, link.col_strobe_n, link.write_en_n} <=
        cmd_valid_i ? strobes(cmd_i) : 3'h7;
      link.clock_gate_in <= cke_i;
      link.byte_lane_mask <= mask_i;
      link.bank_select <= bank_i;
      link.row_col_address <= addr_i;
      link.register_mode_sel <= regmode_i;
      link.spd_addr_strap <= strap_i;
    end
  end

  // ************************
  // Write data, one clock later in registered mode
  // ************************
  logic [8*LANES-1:0] wd_r;
  logic drv_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_r <= '0;
      drv_r <= 1'b0;
      link.host_dq <= '0;
      link.host_dq_oe_n <= '1;
    end else begin
      wd_r <= wr_data_i;
      drv_r <= wr_drive_i;
      link.host_dq <= regmode_i ? wd_r : wr_data_i;
      link.host_dq_oe_n <= {LANES{~(regmode_i ? drv_r : wr_drive_i)}};
    end
  end

  // ************************
  // Serial presence-detect clock divider
  // ************************
  logic [$clog2(SPD_HALF+1)-1:0] div_r;
  logic tick;

  assign tick = div_r == ($bits(div_r))'(SPD_HALF - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
      link.spd_serial_clk <= 1'b1;
    end else if (!spd_run_i) begin
      div_r <= '0;
      link.spd_serial_clk <= 1'b1;
    end else begin
      div_r <= tick ? '0 : div_r + 1'b1;
      if (tick) link.spd_serial_clk <= ~link.spd_serial_clk;
    end
  end

  // ************************
  // Read return tracking
  // ************************
  logic [8:0] rd_sr_r;
  logic [3:0] lat;

  // Register mode costs one more clock of read latency
  assign lat = {1'b0, cl_i} + {3'h0, regmode_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_sr_r <= 9'h000;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end else begin
      rd_sr_r <= {rd_sr_r[7:0], cmd_valid_i && cmd_i == CMD_RD};
      rd_valid_o <= rd_sr_r[lat];
      rd_data_o <= link.dq;
    end
  end

endmodule : sdcmd_host
`default_nettype wire

// File: inc/sdcmd_defines.svh
// Constants shared by both ends of the module command link
//
// Overview of operation
// - Command coded on strobes plus chip select
// - Clock gate low stops the internal clock; read data pipe keeps running
// - Clock gate sampled async in power-down modes
// - Input buffers off during power-down and self refresh
// - Chip select high masks every command
// - Masked read lanes go idle two clocks later, three in register mode
// - Bank lines choose the bank of each command
// - Address carries row, then column
// - Address bit ten flags auto precharge
// - Precharge bit ten picks one or all banks
// - Mode load: address is opcode, bank picks register
// - Serial clock times presence-detect transfers
// - System drives the presence-detect address straps
// - One clock reference for every device
// - Register mode adds one stage to commands
// - Register mode adds one clock read latency
// - Bursts of 1, 2, 4, 8 or page, terminable
`ifndef SDCMD_DEFINES_SVH
`define SDCMD_DEFINES_SVH

// ************************
// Field positions
// ************************
`define SDCMD_AP_BIT 10
`define SDCMD_MR_BL_LSB 0
`define SDCMD_MR_CL_LSB 4
`define SDCMD_BL_FULL 3'h7

// ************************
// Reset values and timing counts
// ************************
`define SDCMD_MR_RESET 13'h0032
`define SDCMD_EMR_RESET 13'h0000
`define SDCMD_CA_IDLE 21'h1f0000
`define SDCMD_MASK_LAT 2
`define SDCMD_SPD_HALF 125

`endif

// File: inc/sdcmd_if.sv
// Pin-level link between memory controller and memory module
`timescale 1ns/10ps
`default_nettype none
interface sdcmd_if #(parameter int LANES = 8);
  logic chip_select_n_low_half;
  logic chip_select_n_high_half;
  logic row_strobe_n;
  logic col_strobe_n;
  logic write_en_n;
  logic clock_gate_in;
  logic [LANES-1:0] byte_lane_mask;
  logic [1:0] bank_select;
  logic [12:0] row_col_address;
  logic register_mode_sel;
  logic [2:0] spd_addr_strap;
  logic spd_serial_clk;
  logic [8*LANES-1:0] host_dq;
  logic [LANES-1:0] host_dq_oe_n;
  logic [8*LANES-1:0] dev_dq;
  logic [LANES-1:0] dev_dq_oe_n;
  logic [8*LANES-1:0] dq;

  // Wire level per lane: the module wins while it drives
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign dq[8*l +: 8] = !dev_dq_oe_n[l] ? dev_dq[8*l +: 8] :
                          host_dq[8*l +: 8];
  end

  modport dev (
    input chip_select_n_low_half, chip_select_n_high_half, row_strobe_n,
    input col_strobe_n, write_en_n, clock_gate_in, byte_lane_mask,
    input bank_select, row_col_address, register_mode_sel,
    input spd_addr_strap, spd_serial_clk, dq,
    output dev_dq, dev_dq_oe_n
  );

  modport host (
    output chip_select_n_low_half, chip_select_n_high_half, row_strobe_n,
    output col_strobe_n, write_en_n, clock_gate_in, byte_lane_mask,
    output bank_select, row_col_address, register_mode_sel,
    output spd_addr_strap, spd_serial_clk, host_dq, host_dq_oe_n,
    input dq
  );
endinterface : sdcmd_if
`default_nettype wire

// File: inc/sdcmd_pkg.sv
// Types shared by both ends of the module command link
package sdcmd_pkg;

  typedef enum logic [3:0] {
    CMD_DESEL = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACT = 4'h2,
    CMD_RD = 4'h3,
    CMD_WR = 4'h4,
    CMD_PRE = 4'h5,
    CMD_REF = 4'h6,
    CMD_LMR = 4'h7,
    CMD_BST = 4'h8
  } sdcmd_cmd_t;

  typedef enum logic [1:0] {
    PW_RUN = 2'h0,
    PW_SUSP = 2'h1,
    PW_PDN = 2'h3,
    PW_SREF = 2'h2
  } sdcmd_pwr_t;

  typedef struct packed {
    logic [1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] ba;
    logic [12:0] a;
  } sdcmd_ca_t;

endpackage : sdcmd_pkg

// File: verification/sdcmd_sva.sv
// Pin-level checks on the command link between the two ends
`timescale 1ns/10ps
`default_nettype none
module sdcmd_sva #(
  parameter int LANES = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic chip_select_n_low_half, // Select
  input wire logic chip_select_n_high_half, // Select
  input wire logic row_strobe_n, // Strobe
  input wire logic col_strobe_n, // Strobe
  input wire logic write_en_n, // Strobe
  input wire logic clock_gate_in, // Gate
  input wire logic [LANES-1:0] byte_lane_mask, // Masks
  input wire logic register_mode_sel, // Mode
  input wire logic spd_serial_clk, // Serial clock
  input wire logic [LANES-1:0] host_dq_oe_n, // Host drive
  input wire logic [LANES-1:0] dev_dq_oe_n // Module drive
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] idle_r;
  logic rd_pin, any_cs, quiet;
  // ****************************************
  // Cycles since a selected read on the pins
  // ****************************************
  assign rd_pin = row_strobe_n && !col_strobe_n && write_en_n;
  assign any_cs = !(chip_select_n_low_half && chip_select_n_high_half);
  // Long enough for a four-beat burst in either mode to drain
  assign quiet = idle_r > 4'h9;
  always_ff @(posedge clk_i) begin
    if (rst_i || (rd_pin && any_cs)) begin
      idle_r <= 4'h0;
    end else if (idle_r != 4'hf) begin
      idle_r <= idle_r + 4'h1;
    end
  end
  sequence s_rd(m);
    (clock_gate_in && register_mode_sel == m)[*5] ##0
    (rd_pin && !chip_select_n_low_half && !chip_select_n_high_half);
  endsequence
  property p_nocontend;
    (host_dq_oe_n | dev_dq_oe_n) == '1;
  endproperty
  property p_mask;
    (~dev_dq_oe_n & $past(byte_lane_mask, 2)) == '0;
  endproperty
  property p_rd_buf;
    s_rd(1'b0) |-> ##3 (dev_dq_oe_n == $past(byte_lane_mask, 2))[*4];
  endproperty
  property p_rd_reg;
    s_rd(1'b1) |-> ##4 (dev_dq_oe_n == $past(byte_lane_mask, 3))[*4];
  endproperty
  property p_quiet;
    quiet |-> dev_dq_oe_n == '1;
  endproperty
  property p_cs;
    quiet && rd_pin && !any_cs |=> (dev_dq_oe_n == '1)[*6];
  endproperty
  property p_rd_lo;
    quiet && rd_pin && !chip_select_n_low_half && chip_select_n_high_half
    |=> (dev_dq_oe_n[LANES-1:LANES/2] == '1)[*7];
  endproperty
  property p_spd;
    $changed(spd_serial_clk) |=> $stable(spd_serial_clk);
  endproperty
  a_nocontend: assert property (p_nocontend)
    else $error("both ends drive data");
  a_mask: assert property (p_mask)
    else $error("masked lane driven");
  a_rd_buf: assert property (p_rd_buf)
    else $error("buffered read timing");
  a_rd_reg: assert property (p_rd_reg)
    else $error("registered read timing");
  a_quiet: assert property (p_quiet)
    else $error("drive without read");
  a_cs: assert property (p_cs)
    else $error("deselected read acted");
  a_rd_lo: assert property (p_rd_lo)
    else $error("unselected half driven");
  a_spd: assert property (p_spd)
    else $error("serial clock too fast");
endmodule : sdcmd_sva
`default_nettype wire

// File: verification/sdram_module_command_inputs_bench.sv
// Bench joining the controller end and the module end
`timescale 1ns/10ps
`default_nettype none
module sdram_module_command_inputs_bench
  import sdcmd_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cv = 1'b0, ck = 1'b1, rm = 1'b0, wd = 1'b0, sr = 1'b0;
  logic rv, wv, rf, ib, sk;
  sdcmd_cmd_t cmd = CMD_NOP;
  sdcmd_pwr_t ps;
  logic [1:0] cs = 2'h3, bk = 2'h0, ab, wb;
  logic [12:0] ad = 13'h0000, wr, mr, em;
  logic [10:0] ac, wc;
  logic [7:0] mk = 8'h00, le;
  logic [63:0] wdat = 64'h0123456789abcdef, rdd, rdo, wdo;
  logic [2:0] st = 3'h0, sto;
  logic [3:0] bo;
  int mismatches = 0, comparisons = 0, n = 0;
  always #5 clk_i = ~clk_i;
  // Array data names its own bank and column
  assign rdd = {8{ab, ac[5:0]}};
  sdcmd_if lnk ();
  sdcmd_host #(.SPD_HALF(2)) i_sdcmd_host (.clk_i(clk_i), .rst_i(rst_i),
    .link(lnk.host), .cmd_valid_i(cv), .cmd_i(cmd), .cs_half_i(cs),
    .bank_i(bk), .addr_i(ad), .cke_i(ck), .mask_i(mk), .regmode_i(rm),
    .cl_i(3'h3), .wr_drive_i(wd), .wr_data_i(wdat), .strap_i(st),
    .spd_run_i(sr), .rd_valid_o(rv), .rd_data_o(rdo));
  sdcmd_device i_sdcmd_device (.clk_i(clk_i), .rst_i(rst_i),
    .link(lnk.dev), .acc_rd_o(), .acc_bank_o(ab), .acc_row_o(),
    .acc_col_o(ac), .rd_data_i(rdd), .wr_valid_o(wv), .wr_bank_o(wb),
    .wr_row_o(wr), .wr_col_o(wc), .wr_data_o(wdo), .wr_lane_en_o(le),
    .refresh_o(rf), .mode_reg_o(mr), .ext_mode_reg_o(em),
    .power_state_o(ps), .input_buf_en_o(ib), .bank_open_o(bo),
    .spd_clk_rise_o(sk), .spd_strap_o(sto));
  sdcmd_sva i_sdcmd_sva (.clk_i(clk_i), .rst_i(rst_i),
    .chip_select_n_low_half(lnk.chip_select_n_low_half),
    .chip_select_n_high_half(lnk.chip_select_n_high_half),
    .row_strobe_n(lnk.row_strobe_n), .col_strobe_n(lnk.col_strobe_n),
    .write_en_n(lnk.write_en_n), .clock_gate_in(lnk.clock_gate_in),
    .byte_lane_mask(lnk.byte_lane_mask),
    .register_mode_sel(lnk.register_mode_sel),
    .spd_serial_clk(lnk.spd_serial_clk), .host_dq_oe_n(lnk.host_dq_oe_n),
    .dev_dq_oe_n(lnk.dev_dq_oe_n));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] s, e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic issue(input sdcmd_cmd_t c, input logic [1:0] b,
                       input logic [12:0] a);
    @(negedge clk_i);
    cv = 1'b1;
    cmd = c;
    bk = b;
    ad = a;
    @(negedge clk_i);
    cv = 1'b0;
  endtask : issue
  task automatic await(ref logic s);
    for (int i = 0; i < 40 && s !== 1'b1; i++) @(negedge clk_i);
    chk("pulse", s, 1'b1);
  endtask : await
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge clk_i);
    issue(CMD_LMR, 2'h0, 13'h1032);
    issue(CMD_LMR, 2'h1, 13'h0155);
    issue(CMD_LMR, 2'h2, 13'h0abc);
    repeat (3) @(negedge clk_i);
    chk("mode", mr, 13'h1032);
    chk("ext", em, 13'h0155);
    $display("end mode");
    issue(CMD_ACT, 2'h2, 13'h1abc);
    mk = 8'h0f;
    wd = 1'b1;
    issue(CMD_WR, 2'h2, 13'h0805);
    wd = 1'b0;
    await(wv);
    chk("bank", wb, 2'h2);
    chk("row", wr, 13'h1abc);
    chk("col", wc, 11'h405);
    chk("lanes", le, 8'hf0);
    chk("data", wdo[63:32], 32'h01234567);
    $display("end write");
    issue(CMD_RD, 2'h2, 13'h0003);
    await(rv);
    chk("read", rdo[63:32], 32'h83838383);
    chk("masked", rdo[31:0], wdat[31:0]);
    mk = 8'h00;
    repeat (12) @(negedge clk_i);
    cs = 2'h1;
    issue(CMD_RD, 2'h2, 13'h0004);
    cs = 2'h3;
    await(rv);
    chk("low half", rdo[31:0], {4{8'h84}});
    rm = 1'b1;
    repeat (4) @(negedge clk_i);
    issue(CMD_RD, 2'h2, 13'h0405);
    await(rv);
    chk("reg read", rdo, {8{8'h85}});
    repeat (10) @(negedge clk_i);
    chk("auto pre", bo, 4'h0);
    rm = 1'b0;
    repeat (4) @(negedge clk_i);
    $display("end read");
    issue(CMD_ACT, 2'h0, 13'h0011);
    issue(CMD_ACT, 2'h1, 13'h0022);
    issue(CMD_PRE, 2'h0, 13'h0000);
    repeat (3) @(negedge clk_i);
    chk("pre one", bo, 4'h2);
    issue(CMD_PRE, 2'h3, 13'h0400);
    repeat (3) @(negedge clk_i);
    chk("pre all", bo, 4'h0);
    cs = 2'h0;
    issue(CMD_ACT, 2'h3, 13'h0001);
    issue(CMD_RD, 2'h3, 13'h0001);
    cs = 2'h3;
    repeat (3) @(negedge clk_i);
    chk("deselect", bo, 4'h0);
    issue(CMD_WR, 2'h1, 13'h0000);
    issue(CMD_BST, 2'h1, 13'h0000);
    repeat (4) begin
      @(negedge clk_i);
      n += wv;
    end
    chk("terminate", n, 1);
    n = 0;
    issue(CMD_REF, 2'h0, 13'h0000);
    await(rf);
    $display("end bank");
    ck = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("pdn", ps, PW_PDN);
    chk("buffers", ib, 1'b0);
    ck = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("wake", ps, PW_RUN);
    // Gate falls with the refresh itself, else power-down wins
    @(negedge clk_i);
    cmd = CMD_REF;
    cv = 1'b1;
    ck = 1'b0;
    @(negedge clk_i);
    cv = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("sref", ps, PW_SREF);
    ck = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("wake", ps, PW_RUN);
    $display("end power");
    st = 3'h5;
    sr = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      n += sk;
    end
    sr = 1'b0;
    chk("strap", sto, 3'h5);
    chk("spd", n > 8 && n < 12, 1'b1);
    $display("end spd");
    final_report();
  end
  initial begin
    // Tests take about 200 cycles
    #(3000 * 10);
    mismatches++;
    final_report();
  end
endmodule : sdram_module_command_inputs_bench
`default_nettype wire
